//--- src/jbu_core.sv
// Jump and branch unit: decodes the ten jumps and produces the next program counter
//
// What this block does
// - Second byte low, third byte high target.
// - Nine jumps three bytes; register-pair jump one.
// - Register-pair jump loads counter from H,L.
// - Unconditional jump always loads byte target.
// - Carry-set jump taken when carry is 1.
// - Carry-clear jump taken when carry is 0.
// - Zero-set jump taken when zero is 1.
// - Zero-clear jump taken when zero is 0.
// - Negative jump taken when sign is 1.
// - Positive jump taken when sign is 0.
// - Even-parity jump taken when parity is 1.
// - Odd-parity jump taken when parity is 0.
// - False condition continues sequentially.
module jbu_core
   import jbu_pkg::*;
(
   input wire logic clk, // 40 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic byte_valid, // Fetch presents a byte
   input wire logic [7:0] byte_data, // Fetched byte
   input wire logic [15:0] pc_in, // Address of the opcode byte
   input wire logic [7:0] reg_h, // H register
   input wire logic [7:0] reg_l, // L register
   input wire logic flag_carry, // Carry flag
   input wire logic flag_zero, // Zero flag
   input wire logic flag_sign, // Sign flag
   input wire logic flag_parity, // Parity flag
   output logic pc_load, // One-cycle pulse: pc_next is valid
   output logic [15:0] pc_next, // Next program counter
   output logic jump_taken, // With pc_load: jump was taken
   output logic busy, // Collecting address bytes
   output logic flags_write // Always low: jumps leave flags alone
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   jbu_state_e state;
   logic [7:0] opcode;
   logic [7:0] addr_low;
   logic [15:0] op_pc;

   wire logic is_pair = byte_data == OP_JUMP_VIA_REGISTER_PAIR;
   wire logic is_always = byte_data == OP_JUMP_ALWAYS;
   wire logic is_cond = jbu_is_cond(byte_data);
   wire logic is_long = is_always || is_cond;
   wire logic start = (state == JBU_IDLE) && byte_valid;
   wire logic take = (opcode == OP_JUMP_ALWAYS) ||
      jbu_cond_met(opcode, flag_carry, flag_zero, flag_sign, flag_parity);
   // byte two low, byte three high
   wire logic [15:0] target = {byte_data, addr_low};
   // untaken jump skips three bytes; sequential flow
   wire logic [15:0] seq_pc = op_pc + PC_STEP_LONG;
   wire logic finish = (state == JBU_HIGH) && byte_valid;

   jbu_state_e next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         JBU_IDLE: if (byte_valid && is_long) next_state = JBU_LOW;
         JBU_LOW: if (byte_valid) next_state = JBU_HIGH;
         JBU_HIGH: if (byte_valid) next_state = JBU_IDLE;
      endcase
   end

   // ----------------------------------------
   // State and outputs
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= JBU_IDLE;
         opcode <= 8'h00;
         addr_low <= 8'h00;
         op_pc <= PC_RESET;
      end else begin
         state <= next_state;
         // Non-jump opcodes are latched too but never reach the outputs
         if (start) begin
            opcode <= byte_data;
            op_pc <= pc_in;
         end
         if (state == JBU_LOW && byte_valid) addr_low <= byte_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_load <= 1'b0;
         pc_next <= PC_RESET;
         jump_taken <= 1'b0;
         busy <= 1'b0;
         flags_write <= 1'b0;
      end else begin
         busy <= next_state != JBU_IDLE;
         flags_write <= 1'b0;
         if (start && is_pair) begin
            pc_load <= 1'b1;
            pc_next <= {reg_h, reg_l};
            jump_taken <= 1'b1;
         end else if (finish) begin
            pc_load <= 1'b1;
            pc_next <= take ? target : seq_pc;
            jump_taken <= take;
         end else begin
            // pc_next keeps its last value, so a late fetch still sees it
            pc_load <= 1'b0;
            jump_taken <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Steps of a three-byte jump: opcode, low byte, high byte, answer
   sequence long_start_s;
      start && is_long;
   endsequence

   sequence long_done_s;
      byte_valid && state == JBU_HIGH;
   endsequence

   sequence long_op_done_s(logic [7:0] op);
      long_done_s ##0 opcode == op;
   endsequence

   // Opcode seen in idle that is neither of the two jump forms
   sequence other_op_s;
      start && !is_long && !is_pair;
   endsequence

   // Register-pair target, unconditional jump taken, byte order of every taken three-byte target
   pair_load_a: assert property (@(posedge clk) disable iff (rst)
      start && is_pair |=> pc_load && jump_taken && pc_next == {$past(reg_h), $past(reg_l)})
      else $error("register-pair jump did not load H,L");

   always_target_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ALWAYS) |=> pc_load && jump_taken)
      else $error("unconditional jump not taken");

   byte_order_a: assert property (@(posedge clk) disable iff (rst)
      long_done_s ##0 take |=> pc_next == {$past(byte_data), $past(addr_low)})
      else $error("target bytes in wrong order");

   // Flag tests use the flags seen with the third byte
   carry_set_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_CARRY_SET) |=> jump_taken == $past(flag_carry))
      else $error("carry-set jump wrong");

   carry_clear_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_CARRY_CLEAR) |=> jump_taken == !$past(flag_carry))
      else $error("carry-clear jump wrong");

   zero_set_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_ZERO_SET) |=> jump_taken == $past(flag_zero))
      else $error("zero-set jump wrong");

   zero_clear_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_ZERO_CLEAR) |=> jump_taken == !$past(flag_zero))
      else $error("zero-clear jump wrong");

   sign_neg_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_NEGATIVE) |=> jump_taken == $past(flag_sign))
      else $error("negative jump wrong");

   sign_pos_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_POSITIVE) |=> jump_taken == !$past(flag_sign))
      else $error("positive jump wrong");

   parity_even_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_EVEN_PARITY) |=> jump_taken == $past(flag_parity))
      else $error("even-parity jump wrong");

   parity_odd_a: assert property (@(posedge clk) disable iff (rst)
      long_op_done_s(OP_JUMP_ON_ODD_PARITY) |=> jump_taken == !$past(flag_parity))
      else $error("odd-parity jump wrong");

   // Sequential flow and held outputs
   untaken_skip_a: assert property (@(posedge clk) disable iff (rst)
      pc_load && !jump_taken |-> pc_next == op_pc + PC_STEP_LONG)
      else $error("untaken jump did not skip three bytes");

   taken_qual_a: assert property (@(posedge clk) disable iff (rst)
      !pc_load |-> !jump_taken)
      else $error("jump reported without a load");

   pc_hold_a: assert property (@(posedge clk) disable iff (rst)
      !pc_load |-> $stable(pc_next))
      else $error("next pc moved without a load");

   // Length of each form: opcode alone, or opcode and two address bytes
   long_len_a: assert property (@(posedge clk) disable iff (rst)
      long_start_s |=> (busy && !pc_load) [*2])
      else $error("long jump finished early");

   finish_load_a: assert property (@(posedge clk) disable iff (rst)
      long_done_s |=> pc_load && !busy)
      else $error("third byte did not end the jump");

   pair_len_a: assert property (@(posedge clk) disable iff (rst)
      start && is_pair |=> !busy)
      else $error("register-pair jump waited for address bytes");

   other_ignored_a: assert property (@(posedge clk) disable iff (rst)
      other_op_s |=> !pc_load && !busy)
      else $error("non-jump opcode acted on");

   // Flags are never written, taken or not
   flags_kept_a: assert property (@(posedge clk) disable iff (rst)
      !flags_write)
      else $error("jump wrote flags");

endmodule

//--- shared/jbu_pkg.sv
// Package for the jump and branch unit: opcodes, widths, condition decode
package jbu_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 16;

   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [7:0] OP_JUMP_VIA_REGISTER_PAIR = 8'hE9; // 11 101 001
   localparam logic [7:0] OP_JUMP_ALWAYS = 8'hC3;            // 11 000 011
   localparam logic [7:0] OP_JUMP_ON_CARRY_SET = 8'hDA;      // 11 011 010
   localparam logic [7:0] OP_JUMP_ON_CARRY_CLEAR = 8'hD2;    // 11 010 010
   localparam logic [7:0] OP_JUMP_ON_ZERO_SET = 8'hCA;       // 11 001 010
   localparam logic [7:0] OP_JUMP_ON_ZERO_CLEAR = 8'hC2;     // 11 000 010
   localparam logic [7:0] OP_JUMP_ON_NEGATIVE = 8'hFA;       // 11 111 010
   localparam logic [7:0] OP_JUMP_ON_POSITIVE = 8'hF2;       // 11 110 010
   localparam logic [7:0] OP_JUMP_ON_EVEN_PARITY = 8'hEA;    // 11 101 010
   localparam logic [7:0] OP_JUMP_ON_ODD_PARITY = 8'hE2;     // 11 100 010

   // Conditional jumps share 11 ccc 010; ccc picks flag and sense
   localparam logic [1:0] COND_TOP = 2'h3;
   localparam logic [2:0] COND_LOW = 3'h2;

   // ----------------------------------------
   // Reset values and step sizes
   // ----------------------------------------
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] PC_STEP_SHORT = 16'h0001;
   localparam logic [15:0] PC_STEP_LONG = 16'h0003;

   typedef enum logic [1:0] {
      JBU_IDLE,
      JBU_LOW,
      JBU_HIGH
   } jbu_state_e;

   // True when the opcode is one of the eight conditional jumps
   function automatic logic jbu_is_cond(input logic [7:0] op);
      return (op[7:6] == COND_TOP) && (op[2:0] == COND_LOW);
   endfunction

   // Condition test: ccc[2:1] selects zero, carry, parity, sign; ccc[0] is the sense
   function automatic logic jbu_cond_met(input logic [7:0] op, input logic cy,
                                         input logic zr, input logic sg, input logic pa);
      logic f;
      unique case (op[5:4])
         2'h0: f = zr;
         2'h1: f = cy;
         2'h2: f = pa;
         2'h3: f = sg;
      endcase
      return f == op[3];
   endfunction

endpackage

//--- dv/jbu_fetch_model.sv
// Fetch, flag and register-file model feeding the jump unit
module jbu_fetch_model (
   input wire logic clk, // Processor clock
   output logic byte_valid, // Byte offered
   output logic [7:0] byte_data, // Offered byte
   output logic [15:0] pc_in, // Opcode address
   output logic [7:0] reg_h, // H register
   output logic [7:0] reg_l, // L register
   output logic [3:0] flags // Parity, sign, zero, carry
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      byte_valid = 1'b0;
      byte_data = 8'h00;
      pc_in = 16'h0000;
      reg_h = 8'h00;
      reg_l = 8'h00;
      flags = 4'h0;
   end
   // Offers one instruction; a gap stalls between the two address bytes
   task automatic send(input logic [7:0] op, lo, hi, input logic [15:0] pc,
                       input logic [7:0] h, l, input logic [3:0] f, input logic gap);
      @(posedge clk);
      byte_valid <= 1'b1;
      byte_data <= op;
      pc_in <= pc;
      reg_h <= h;
      reg_l <= l;
      flags <= f;
      if (op == 8'hC3 || (op[7:6] == 2'h3 && op[2:0] == 3'h2)) begin
         @(posedge clk);
         byte_data <= lo;
         if (gap) begin
            @(posedge clk);
            byte_valid <= 1'b0;
            byte_data <= ~lo;
         end
         @(posedge clk);
         byte_valid <= 1'b1;
         byte_data <= hi;
      end
      @(posedge clk);
      byte_valid <= 1'b0;
      // Released bus must not keep showing the last byte
      byte_data <= ~byte_data;
   endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the jump and branch unit
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bv, pc_load, jump_taken, busy, flags_write;
   logic [7:0] bd, rh, rl;
   logic [15:0] pc_in, pc_next;
   logic [3:0] fl;
   int failures = 0;
   int checked = 0;
   int busy_seen = 0;
   logic [31:0] s = 32'h0000_c53d;
   logic [7:0] ops [10] = '{8'hE9, 8'hC3, 8'hDA, 8'hD2, 8'hCA, 8'hC2, 8'hFA, 8'hF2, 8'hEA, 8'hE2};
   always #12.5 clk = ~clk;
   // Edges at which the unit reports itself busy, read before the edge updates it
   always @(posedge clk) begin
      if (busy === 1'b1) busy_seen++;
   end
   jbu_fetch_model fm (.clk(clk), .byte_valid(bv), .byte_data(bd), .pc_in(pc_in),
      .reg_h(rh), .reg_l(rl), .flags(fl));
   jbu_core dut (.clk(clk), .rst(rst), .byte_valid(bv), .byte_data(bd), .pc_in(pc_in),
      .reg_h(rh), .reg_l(rl), .flag_carry(fl[0]), .flag_zero(fl[1]), .flag_sign(fl[2]),
      .flag_parity(fl[3]), .pc_load(pc_load), .pc_next(pc_next), .jump_taken(jump_taken),
      .busy(busy), .flags_write(flags_write));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return x[0] ? ((x >> 1) ^ 32'h8020_0003) : (x >> 1);
   endfunction
   function automatic logic take(input logic [7:0] op, input logic [3:0] f);
      case (op)
         8'hDA: return f[0];
         8'hD2: return !f[0];
         8'hCA: return f[1];
         8'hC2: return !f[1];
         8'hFA: return f[2];
         8'hF2: return !f[2];
         8'hEA: return f[3];
         8'hE2: return !f[3];
         default: return 1'b1;
      endcase
   endfunction
   task automatic check(input logic [16:0] act, input logic [16:0] exp, input string what);
      checked++;
      if (act !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, act, exp);
      end
   endtask
   task automatic results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Whole run is under a thousand cycles; this 8000-cycle limit bounds a hang
   initial begin
      #200_000;
      failures++;
      results();
   end
   initial begin
      logic [7:0] op;
      logic [15:0] pc, exp;
      logic [3:0] f;
      logic t;
      int busy_from;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({pc_load, pc_next}, 17'h0_0000, "reset");
      // First twenty walk every opcode with all flags clear, then all set
      for (int i = 0; i < 120; i++) begin
         s = lfsr(s);
         op = (i < 20) ? ops[i % 10] : (s[7:4] == 4'h0 ? 8'hCD : ops[s[11:8] % 10]);
         f = (i < 20) ? {4{i >= 10}} : s[27:24];
         pc = (i % 10 == 3) ? 16'hFFFE : s[31:16];
         busy_from = busy_seen;
         fm.send(op, s[15:8], s[23:16], pc, s[31:24], s[7:0], f, s[4]);
         @(negedge clk);
         t = take(op, f);
         exp = (op == 8'hE9) ? {s[31:24], s[7:0]} : (t ? {s[23:16], s[15:8]} : pc + 16'h0003);
         if (op == 8'hCD) begin
            check({15'h0000, pc_load, busy}, 17'h0_0000, "ignored");
         end else begin
            check({pc_load, pc_next}, {1'b1, exp}, "next pc");
            check({14'h0, busy, jump_taken, flags_write}, {15'h0, t, 1'b0}, "status");
         end
         // Opcode alone: never busy; three-byte forms: two edges plus any stall
         exp = (op == 8'hE9 || op == 8'hCD) ? 16'h0000 : 16'h0002 + {15'h0000, s[4]};
         check({1'b0, 16'(busy_seen - busy_from)}, {1'b0, exp}, "busy span");
      end
      results();
   end
endmodule
